// file: asl_consts.svh
// Constants for the ASCII serial slave: characters, codes, register map, limits
`ifndef ASL_CONSTS_SVH
`define ASL_CONSTS_SVH
`define ASL_CHR_COLON 8'h3a
`define ASL_CHR_CR 8'h0d
`define ASL_CHR_LF 8'h0a
`define ASL_FC_READ 8'h03
`define ASL_FC_WRITE 8'h06
`define ASL_REG_TEMP 16'h0000
`define ASL_REG_PRESS 16'h0002
`define ASL_REG_STATUS 16'h0004
`define ASL_REG_ALARM1 16'h0005
`define ASL_REG_ALARM2 16'h0006
`define ASL_REG_RUN 16'h000c
`define ASL_RUN_START_VAL 16'h0001
`define ASL_RUN_RESET 16'h0000
`define ASL_SLAVE_MIN 7'h01
`define ASL_SLAVE_MAX 7'h63
`define ASL_SLAVE_DEFAULT 7'h01
`define ASL_REQ_BYTES 4'h7
`define ASL_QTY_MAX 16'h007d
`define ASL_WRITE_REPLY_LEN 9'h006
`define ASL_READ_HDR_LEN 9'h003
`endif

// file: asl_pkg.sv
// Types for the ASCII serial slave
`default_nettype none
package asl_pkg;
    // Frame handler states
    typedef enum logic [3:0] {
        ST_HUNT = 4'b0000,
        ST_BODY = 4'b0001,
        ST_LF = 4'b0010,
        ST_TX_COLON = 4'b0011,
        ST_TX_HI = 4'b0100,
        ST_TX_LO = 4'b0101,
        ST_TX_CR = 4'b0110,
        ST_TX_LF = 4'b0111
    } asl_state_t;
endpackage
`default_nettype wire

// file: asl_slave.sv
// ASCII framed register slave with check byte, read-many and write-one
`timescale 1ns/1ps
`default_nettype none
`include "asl_consts.svh"

module asl_slave (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    input wire logic tx_ready,
    input wire logic [6:0] slave_addr,
    input wire logic [15:0] temperature,
    input wire logic [15:0] pressure,
    input wire logic [15:0] status_word,
    input wire logic [15:0] alarm_first,
    input wire logic [15:0] alarm_second,
    output logic [7:0] tx_char,
    output logic tx_valid,
    output logic [15:0] run_stop_word,
    output logic run_start
);
    // Nibble to upper-case ASCII hex
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    // ASCII hex to nibble; bit 4 marks a legal digit, either case accepted
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        hex_val = 5'h00;
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_val = {1'b1, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            hex_val = {1'b1, c[3:0] + 4'h9};
        end
    endfunction

    asl_pkg::asl_state_t state_r, state_nxt; // Frame handler state
    logic [7:0] buf_r [0:6]; // Received request bytes
    logic [7:0] buf_nxt [0:6];
    logic [3:0] cnt_r, cnt_nxt; // Bytes received so far
    logic half_r, half_nxt; // High nibble waiting for its partner
    logic [3:0] hi_r, hi_nxt; // Held high nibble
    logic bad_r, bad_nxt; // Bad digit or too many bytes
    logic [7:0] sum_r, sum_nxt; // Running sum of received bytes
    logic [8:0] idx_r, idx_nxt; // Reply byte being sent
    logic [7:0] cur_r, cur_nxt; // Reply byte being sent, value
    logic [7:0] tsum_r, tsum_nxt; // Running sum of sent bytes
    logic [7:0] tx_char_r, tx_char_nxt;
    logic tx_valid_r, tx_valid_nxt;
    logic [15:0] run_r, run_nxt; // Run/stop command word
    logic run_start_r, run_start_nxt;

    // Decoded request and helpers
    logic rx_colon, rx_lf, frame_ok, tx_busy, hs;
    logic [4:0] hv;
    logic [6:0] my_addr;
    logic [15:0] req_reg, req_val, rd_addr, rd_word;
    logic [8:0] reply_len, fetch_idx, word_off;
    logic [7:0] fetch_byte, byte_in, lrc_out;

    assign tx_char = tx_char_r;
    assign tx_valid = tx_valid_r;
    assign run_stop_word = run_r;
    assign run_start = run_start_r;

    assign rx_colon = rx_valid && rx_char == `ASL_CHR_COLON;
    assign rx_lf = rx_valid && rx_char == `ASL_CHR_LF;
    assign hv = hex_val(rx_char);
    assign byte_in = {hi_r, hv[3:0]};
    assign tx_busy = state_r[2] || state_r == asl_pkg::ST_TX_COLON;
    assign hs = tx_valid_r && tx_ready;
    // Out-of-range settings fall back to the default address
    assign my_addr = (slave_addr >= `ASL_SLAVE_MIN && slave_addr <= `ASL_SLAVE_MAX)
        ? slave_addr : `ASL_SLAVE_DEFAULT;
    assign req_reg = {buf_r[2], buf_r[3]};
    assign req_val = {buf_r[4], buf_r[5]};
    // All seven bytes including the check must sum to zero modulo 256
    assign frame_ok = cnt_r == `ASL_REQ_BYTES && !bad_r && !half_r && sum_r == 8'h00
        && buf_r[0] == {1'b0, my_addr}
        && ((buf_r[1] == `ASL_FC_READ && req_val != 16'h0000 && req_val <= `ASL_QTY_MAX)
        || buf_r[1] == `ASL_FC_WRITE);
    // Reply length in bytes, check byte excluded
    assign reply_len = (buf_r[1] == `ASL_FC_READ)
        ? `ASL_READ_HDR_LEN + {req_val[7:0], 1'b0} : `ASL_WRITE_REPLY_LEN;
    assign fetch_idx = (state_r == asl_pkg::ST_TX_COLON) ? 9'h000 : idx_r + 9'h001;
    assign word_off = fetch_idx - `ASL_READ_HDR_LEN;
    assign rd_addr = req_reg + {8'h00, word_off[8:1]};
    assign lrc_out = ~(tsum_r + cur_r) + 8'h01;

    // Register read map; unmapped and reserved words read zero
    always_comb begin
        unique case (rd_addr)
            `ASL_REG_TEMP: rd_word = temperature;
            `ASL_REG_PRESS: rd_word = pressure;
            `ASL_REG_STATUS: rd_word = status_word;
            `ASL_REG_ALARM1: rd_word = alarm_first;
            `ASL_REG_ALARM2: rd_word = alarm_second;
            `ASL_REG_RUN: rd_word = run_r;
            default: rd_word = 16'h0000;
        endcase
    end

    // Next reply byte: header, then words high byte first, or the echo
    always_comb begin
        fetch_byte = buf_r[fetch_idx[2:0] == 3'h7 ? 3'h6 : fetch_idx[2:0]];
        if (buf_r[1] == `ASL_FC_READ) begin
            if (fetch_idx == 9'h002) begin
                fetch_byte = {req_val[6:0], 1'b0};
            end else if (fetch_idx > 9'h002) begin
                fetch_byte = word_off[0] ? rd_word[7:0] : rd_word[15:8];
            end
        end
    end

    // Frame receiver and reply sender
    always_comb begin
        state_nxt = state_r;
        buf_nxt = buf_r;
        cnt_nxt = cnt_r;
        half_nxt = half_r;
        hi_nxt = hi_r;
        bad_nxt = bad_r;
        sum_nxt = sum_r;
        idx_nxt = idx_r;
        cur_nxt = cur_r;
        tsum_nxt = tsum_r;
        tx_char_nxt = tx_char_r;
        tx_valid_nxt = tx_valid_r;
        run_nxt = run_r;
        run_start_nxt = 1'b0;
        if (!tx_busy && rx_colon) begin
            // Colon restarts assembly wherever the receiver was
            state_nxt = asl_pkg::ST_BODY;
            cnt_nxt = 4'h0;
            half_nxt = 1'b0;
            bad_nxt = 1'b0;
            sum_nxt = 8'h00;
        end else begin
            unique case (state_r)
                asl_pkg::ST_HUNT: begin
                    // Characters before a colon are ignored
                end
                asl_pkg::ST_BODY: begin
                    if (rx_valid && rx_char == `ASL_CHR_CR) begin
                        state_nxt = asl_pkg::ST_LF;
                    end else if (rx_valid && !hv[4]) begin
                        bad_nxt = 1'b1;
                    end else if (rx_valid && !half_r) begin
                        hi_nxt = hv[3:0];
                        half_nxt = 1'b1;
                    end else if (rx_valid) begin
                        half_nxt = 1'b0;
                        if (cnt_r < `ASL_REQ_BYTES) begin
                            buf_nxt[cnt_r[2:0]] = byte_in;
                            sum_nxt = sum_r + byte_in;
                            cnt_nxt = cnt_r + 4'h1;
                        end else begin
                            bad_nxt = 1'b1; // Too long for any served code
                        end
                    end
                end
                asl_pkg::ST_LF: begin
                    if (rx_lf && frame_ok) begin
                        // Act on the request only once it is complete
                        state_nxt = asl_pkg::ST_TX_COLON;
                        tx_char_nxt = `ASL_CHR_COLON;
                        tx_valid_nxt = 1'b1;
                        tsum_nxt = 8'h00;
                        idx_nxt = 9'h000;
                        if (buf_r[1] == `ASL_FC_WRITE && req_reg == `ASL_REG_RUN) begin
                            run_nxt = req_val;
                            run_start_nxt = req_val == `ASL_RUN_START_VAL;
                        end
                    end else if (rx_valid) begin
                        state_nxt = asl_pkg::ST_HUNT;
                    end
                end
                asl_pkg::ST_TX_COLON: begin
                    if (hs) begin
                        state_nxt = asl_pkg::ST_TX_HI;
                        cur_nxt = fetch_byte;
                        tx_char_nxt = hex_char(fetch_byte[7:4]);
                    end
                end
                asl_pkg::ST_TX_HI: begin
                    if (hs) begin
                        state_nxt = asl_pkg::ST_TX_LO;
                        tx_char_nxt = hex_char(cur_r[3:0]);
                    end
                end
                asl_pkg::ST_TX_LO: begin
                    if (hs && idx_r == reply_len) begin
                        state_nxt = asl_pkg::ST_TX_CR;
                        tx_char_nxt = `ASL_CHR_CR;
                    end else if (hs) begin
                        // Check byte follows the last content byte
                        state_nxt = asl_pkg::ST_TX_HI;
                        idx_nxt = idx_r + 9'h001;
                        tsum_nxt = tsum_r + cur_r;
                        cur_nxt = (fetch_idx == reply_len) ? lrc_out : fetch_byte;
                        tx_char_nxt = hex_char(cur_nxt[7:4]);
                    end
                end
                asl_pkg::ST_TX_CR: begin
                    if (hs) begin
                        state_nxt = asl_pkg::ST_TX_LF;
                        tx_char_nxt = `ASL_CHR_LF;
                    end
                end
                asl_pkg::ST_TX_LF: begin
                    if (hs) begin
                        state_nxt = asl_pkg::ST_HUNT;
                        tx_valid_nxt = 1'b0;
                    end
                end
                default: begin
                    state_nxt = asl_pkg::ST_HUNT;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= asl_pkg::ST_HUNT;
            for (int i = 0; i < 7; i++) begin
                buf_r[i] <= 8'h00;
            end
            cnt_r <= 4'h0;
            half_r <= 1'b0;
            hi_r <= 4'h0;
            bad_r <= 1'b0;
            sum_r <= 8'h00;
            idx_r <= 9'h000;
            cur_r <= 8'h00;
            tsum_r <= 8'h00;
            tx_char_r <= 8'h00;
            tx_valid_r <= 1'b0;
            run_r <= `ASL_RUN_RESET;
            run_start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            buf_r <= buf_nxt;
            cnt_r <= cnt_nxt;
            half_r <= half_nxt;
            hi_r <= hi_nxt;
            bad_r <= bad_nxt;
            sum_r <= sum_nxt;
            idx_r <= idx_nxt;
            cur_r <= cur_nxt;
            tsum_r <= tsum_nxt;
            tx_char_r <= tx_char_nxt;
            tx_valid_r <= tx_valid_nxt;
            run_r <= run_nxt;
            run_start_r <= run_start_nxt;
        end
    end

    // Checks on the frame handler
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence cr_sent_s;
        state_r == asl_pkg::ST_TX_CR && tx_ready;
    endsequence
    sequence lf_out_s;
        state_r == asl_pkg::ST_TX_LF && tx_char_r == `ASL_CHR_LF && tx_valid_r;
    endsequence

    check_drop_a: assert property (
        (state_r == asl_pkg::ST_LF && rx_lf && sum_r != 8'h00) |=> state_r == asl_pkg::ST_HUNT)
        else $error("frame with bad check was answered");
    colon_flush_a: assert property (
        (rx_colon && !tx_busy) |=> (cnt_r == 4'h0 && !half_r && state_r == asl_pkg::ST_BODY))
        else $error("colon did not restart the frame");
    reply_cause_a: assert property (
        $rose(state_r == asl_pkg::ST_TX_COLON) |-> $past(state_r == asl_pkg::ST_LF && rx_lf))
        else $error("reply began before the end marker");
    start_char_a: assert property (
        state_r == asl_pkg::ST_TX_COLON |-> (tx_valid_r && tx_char_r == `ASL_CHR_COLON))
        else $error("reply does not open with a colon");
    end_marker_a: assert property (cr_sent_s |=> lf_out_s)
        else $error("CR not followed by LF");
    hex_high_a: assert property (
        state_r == asl_pkg::ST_TX_HI |-> tx_char_r == hex_char(cur_r[7:4]))
        else $error("high nibble not sent as hex");
    foreign_addr_a: assert property (
        (state_r == asl_pkg::ST_LF && rx_lf && buf_r[0] != {1'b0, my_addr})
        |=> state_r == asl_pkg::ST_HUNT ##1 !tx_valid_r)
        else $error("foreign address was answered");
    run_write_a: assert property (
        (state_r == asl_pkg::ST_LF && rx_lf && frame_ok && buf_r[1] == `ASL_FC_WRITE
        && req_reg == `ASL_REG_RUN)
        |=> (run_r == $past(req_val) && run_start_r == ($past(req_val) == 16'h0001)))
        else $error("run word write not applied");
    check_out_a: assert property (
        state_r == asl_pkg::ST_TX_CR |-> 8'(tsum_r + cur_r) == 8'h00)
        else $error("sent check byte does not cancel the sum");
endmodule
`default_nettype wire

// file: asl_host.sv
// Host master model: sends framed ASCII requests and collects reply characters
`timescale 1ns/1ps
`default_nettype none
module asl_host (
    input wire logic sys_clk,
    output logic [7:0] rx_char,
    output logic rx_valid,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] got[$]; // Reply characters accepted from the slave
    bit slow = 1'b0; // Stall the reply every other cycle
    initial begin
        rx_char = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // Check byte: negated low eight bits of the byte sum
    function automatic logic [7:0] lrc(input logic [7:0] b[$]);
        logic [7:0] s;
        s = 8'h00;
        foreach (b[i]) s = s + b[i]; // Body bytes only, carry dropped
        return ~s + 8'h01; // Two's complement
    endfunction
    // Upper-case hex digit
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction
    // One character as a single-cycle pulse, then a quiet cycle
    task automatic put(input logic [7:0] c);
        @(posedge sys_clk);
        rx_char <= c;
        rx_valid <= 1'b1;
        @(posedge sys_clk);
        rx_char <= ~c; // Idle line shows a changed pattern, never the old value
        rx_valid <= 1'b0;
    endtask
    // Whole frame; bad spoils the check byte, cut leaves out the end marker
    task automatic send(input logic [7:0] b[$], input bit bad, input bit cut);
        logic [7:0] c;
        c = lrc(b) ^ {7'h00, bad};
        b.push_back(c); // Sender appends its own
        put(8'h3a); // Start marker
        foreach (b[i]) begin
            put(hx(b[i][7:4])); // High nibble first
            put(hx(b[i][3:0]));
        end
        if (!cut) begin
            put(8'h0d); // End marker
            put(8'h0a);
        end
    endtask
    // Transmit acceptance, optionally stalled
    always @(posedge sys_clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            got.push_back(tx_char);
        end
    end
endmodule
`default_nettype wire

// file: tb_ascii_serial_slave_lrc_rw.sv
// Testbench for the ASCII serial slave: reads, writes, check and address faults
`timescale 1ns/1ps
`default_nettype none
module tb_ascii_serial_slave_lrc_rw;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] rx_char;
    logic rx_valid;
    logic tx_ready;
    logic [6:0] slave_addr = 7'h01;
    logic [15:0] temperature = 16'h0000;
    logic [15:0] pressure = 16'h0000;
    logic [15:0] status_word = 16'h0000;
    logic [15:0] alarm_first = 16'h0000;
    logic [15:0] alarm_second = 16'h0000;
    logic [7:0] tx_char;
    logic tx_valid;
    logic [15:0] run_stop_word;
    logic run_start;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0; // Hang guard
    int starts = 0; // Start pulses seen
    always #12.5 sys_clk = ~sys_clk;
    asl_slave dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .rx_char(rx_char),
        .rx_valid(rx_valid), .tx_ready(tx_ready), .slave_addr(slave_addr),
        .temperature(temperature), .pressure(pressure), .status_word(status_word),
        .alarm_first(alarm_first), .alarm_second(alarm_second), .tx_char(tx_char),
        .tx_valid(tx_valid), .run_stop_word(run_stop_word), .run_start(run_start));
    asl_host host_u (.sys_clk(sys_clk), .rx_char(rx_char), .rx_valid(rx_valid),
        .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready));
    // Count start pulses and cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (run_start === 1'b1) begin
            starts++;
        end
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Hex character to nibble, either case
    function automatic logic [3:0] nib(input logic [7:0] c);
        return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
    endfunction
    // Waits for a whole reply, then checks markers, bytes and check byte
    task automatic cmp_reply(input string what, input logic [7:0] exp[$]);
        logic [7:0] seen[$];
        int k;
        int n;
        exp.push_back(host_u.lrc(exp));
        for (k = 0; k < 400; k++) begin
            n = host_u.got.size();
            if (n > 2 && host_u.got[n - 1] === 8'h0a) break;
            @(posedge sys_clk);
        end
        n = host_u.got.size();
        cmp_val({what, " start"}, 16'h003a, (n > 0) ? {8'h00, host_u.got[0]} : 16'hffff);
        for (k = 1; k + 2 < n; k += 2) seen.push_back({nib(host_u.got[k]), nib(host_u.got[k + 1])});
        cmp_val({what, " end"}, 16'h0d0a, (n > 2) ? {host_u.got[n - 2], host_u.got[n - 1]} : 16'h0);
        cmp_val({what, " length"}, 16'(exp.size()), 16'(seen.size()));
        foreach (exp[i]) if (i < seen.size()) cmp_val(what, {8'h00, exp[i]}, {8'h00, seen[i]});
    endtask
    // No reply within a quiet spell
    task automatic cmp_silent(input string what);
        repeat (80) @(posedge sys_clk);
        cmp_val(what, 16'h0000, 16'(host_u.got.size()));
        host_u.got.delete();
    endtask
    task automatic t_read7();
        @(posedge sys_clk);
        temperature <= 16'h00d4;
        pressure <= 16'h000d;
        status_word <= 16'h0201;
        alarm_first <= 16'ha501;
        alarm_second <= 16'h5a02;
        host_u.slow = 1'b1;
        host_u.got.delete();
        host_u.send('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h07}, 1'b0, 1'b0);
        cmp_reply("read seven", '{8'h01, 8'h03, 8'h0e, 8'h00, 8'hd4, 8'h00, 8'h00, 8'h00, 8'h0d,
            8'h00, 8'h00, 8'h02, 8'h01, 8'ha5, 8'h01, 8'h5a, 8'h02});
        host_u.slow = 1'b0;
        $display("test read seven done");
    endtask
    task automatic t_write_bad();
        host_u.got.delete();
        host_u.send('{8'h01, 8'h06, 8'h00, 8'h0c, 8'h00, 8'h01}, 1'b0, 1'b0);
        cmp_reply("write echo", '{8'h01, 8'h06, 8'h00, 8'h0c, 8'h00, 8'h01});
        cmp_val("run word", 16'h0001, run_stop_word);
        cmp_val("start pulses", 16'h0001, 16'(starts));
        host_u.got.delete();
        host_u.send('{8'h01, 8'h06, 8'h00, 8'h0c, 8'h00, 8'h00}, 1'b1, 1'b0);
        cmp_silent("bad check reply");
        host_u.send('{8'h01, 8'h03, 8'h00, 8'h0c, 8'h00, 8'h01}, 1'b0, 1'b0);
        cmp_reply("run readback", '{8'h01, 8'h03, 8'h02, 8'h00, 8'h01});
        // A write elsewhere is echoed but must leave the run word alone
        host_u.got.delete();
        host_u.send('{8'h01, 8'h06, 8'h00, 8'h0b, 8'h12, 8'h34}, 1'b0, 1'b0);
        cmp_reply("other write echo", '{8'h01, 8'h06, 8'h00, 8'h0b, 8'h12, 8'h34});
        cmp_val("run word kept", 16'h0001, run_stop_word);
        cmp_val("start pulses kept", 16'h0001, 16'(starts));
        $display("test write and bad check done");
    endtask
    task automatic t_addr();
        host_u.got.delete();
        host_u.send('{8'h02, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b0, 1'b0);
        cmp_silent("foreign address reply");
        // Only codes 03 and 06 are served, and a read must ask for at least one word
        host_u.send('{8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h01}, 1'b0, 1'b0);
        cmp_silent("unserved code reply");
        host_u.send('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 1'b0);
        cmp_silent("zero count reply");
        @(posedge sys_clk);
        slave_addr <= 7'h63;
        host_u.send('{8'h63, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b0, 1'b0);
        cmp_reply("address 99", '{8'h63, 8'h03, 8'h02, 8'h00, 8'h0d});
        // An out-of-range setting must behave as the default address
        @(posedge sys_clk);
        slave_addr <= 7'h00;
        host_u.got.delete();
        host_u.send('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b0, 1'b0);
        cmp_reply("illegal setting", '{8'h01, 8'h03, 8'h02, 8'h00, 8'h0d});
        @(posedge sys_clk);
        slave_addr <= 7'h01;
        $display("test address done");
    endtask
    task automatic t_flush();
        host_u.got.delete();
        host_u.put(8'h3a);
        host_u.put(8'h30);
        host_u.put(8'h36);
        host_u.send('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h03}, 1'b0, 1'b0);
        cmp_reply("after flush", '{8'h01, 8'h03, 8'h06, 8'h02, 8'h01, 8'ha5, 8'h01,
            8'h5a, 8'h02});
        host_u.got.delete();
        host_u.send('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b1);
        cmp_silent("no end marker reply");
        $display("test flush done");
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        cmp_val("run word reset", 16'h0000, run_stop_word);
        t_read7();
        t_write_bad();
        t_addr();
        t_flush();
        conclude();
    end
endmodule
`default_nettype wire
